// file: fci_host.sv
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module fci_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output fci_pkg::fci_pins_s pins_o,
  input wire logic [15:0] dq_i,
  input wire logic busy_indicator_out_i,
  output logic reset_powerdown_n_o
);
  import fci_pkg::*;

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  typedef struct packed {
    fci_st_e st;
    fci_pins_s pins;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [4:0] count;
    logic [4:0] idx;
    logic [2:0] step;
    fci_op_e op;
    logic is_read;
    logic buf_wait;
    logic err;
    logic ack;
    logic [3:0] tmr;
    logic rstn;
  } fci_state_s;

  fci_state_s q;
  fci_state_s next_q;
  logic wr_req;

  // a write lands at the edge where the master samples ack, while it still holds the request
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;

  // one bus cycle per step, except the buffered data step, which repeats for each word; the step list gives command then argument
  function automatic logic [8:0] step_word(input fci_op_e op, input logic [2:0] s, input logic [4:0] cnt);
    // bit 8 set means this step is a read, otherwise the low byte is the command, the count, or 8'hFF for the data word
    logic [8:0] w;
    w = 9'h100;
    unique case (op)
      FCI_OP_ARRAY: w = {1'b0, CMD_READ_ARRAY};
      FCI_OP_CLEAR: w = {1'b0, CMD_CLEAR_STATUS};
      FCI_OP_ID: w = (s == 3'h0) ? {1'b0, CMD_READ_ID} : 9'h100;
      FCI_OP_QUERY: w = (s == 3'h0) ? {1'b0, CMD_QUERY} : 9'h100;
      FCI_OP_STATUS: w = (s == 3'h0) ? {1'b0, CMD_READ_STATUS} : 9'h100;
      FCI_OP_ERASE: w = (s == 3'h0) ? {1'b0, CMD_ERASE_SETUP} : {1'b0, CMD_CONFIRM};
      FCI_OP_SUSPEND: w = {1'b0, CMD_SUSPEND};
      FCI_OP_RESUME: w = {1'b0, CMD_CONFIRM};
      FCI_OP_PROG: w = (s == 3'h0) ? {1'b0, CMD_PROG_SETUP} : 9'h0FF;
      FCI_OP_CONFIG: w = (s == 3'h0) ? {1'b0, CMD_CONFIG} : 9'h0FF;
      FCI_OP_LOCK_BLK: w = (s == 3'h0) ? {1'b0, CMD_LOCK_SETUP} : {1'b0, CMD_LOCK_BLOCK};
      FCI_OP_LOCK_MST: w = (s == 3'h0) ? {1'b0, CMD_LOCK_SETUP} : {1'b0, CMD_LOCK_MASTER};
      FCI_OP_UNLOCK: w = (s == 3'h0) ? {1'b0, CMD_LOCK_SETUP} : {1'b0, CMD_CONFIRM};
      FCI_OP_BUFPROG: begin
        // setup, poll buffer status, count, data, confirm
        unique case (s)
          3'h0: w = {1'b0, CMD_BUF_SETUP};
          3'h1: w = 9'h100;
          3'h2: w = {4'h0, cnt};
          3'h3: w = 9'h0FF;
          default: w = {1'b0, CMD_CONFIRM};
        endcase
      end
      default: w = 9'h100;
    endcase
    return w;
  endfunction

  //------------------------------------------------------------
  // sequencer and register slave
  //------------------------------------------------------------
  always_comb begin
    logic [8:0] w;
    logic last;
    w = step_word(q.op, q.step, q.count);
    last = 1'b0;
    next_q = q;
    next_q.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      next_q.ack = 1'b1;
    end
    // register writes; ignored while a sequence runs
    if (wr_req && q.st == FCI_IDLE) begin
      unique case (wb_adr_i)
        REG_ADDR: next_q.addr = wb_dat_i[ADDR_W-1:0];
        REG_DATA: next_q.wdata = wb_dat_i[15:0];
        REG_CTRL: begin
          next_q.op = fci_op_e'(wb_dat_i[3:0]);
          next_q.rstn = wb_dat_i[8];
          next_q.count = (wb_dat_i[20:16] > BUF_COUNT_MAX) ? BUF_COUNT_MAX : wb_dat_i[20:16];
          next_q.step = 3'h0;
          next_q.idx = 5'h0;
          next_q.err = 1'b0;
          if (wb_dat_i[3:0] != 4'h0 && wb_dat_i[8]) begin
            next_q.st = FCI_SETUP;
          end
        end
        default: ;
      endcase
    end
    unique case (q.st)
      FCI_IDLE: begin
        next_q.pins.chip_select_n = 1'b1;
        next_q.pins.out_enable_n = 1'b1;
        next_q.pins.write_enable_n = 1'b1;
        next_q.pins.dq_oe_n = 1'b1;
      end
      FCI_SETUP: begin
        // address and data settle before the strobe opens
        next_q.is_read = w[8] || q.op == FCI_OP_READ;
        next_q.pins.addr = q.addr + ADDR_W'(q.step == 3'h3 ? q.idx : 5'h0);
        next_q.pins.dq_out = w[7:0] == 8'hFF && w[8] == 1'b0 && q.step != 3'h0 ? q.wdata : {8'h00, w[7:0]};
        if (q.op == FCI_OP_ARRAY) begin
          next_q.pins.dq_out = {8'h00, CMD_READ_ARRAY};
        end
        next_q.pins.dq_oe_n = w[8] || q.op == FCI_OP_READ;
        next_q.pins.chip_select_n = 1'b0;
        next_q.tmr = STROBE_CYC;
        next_q.st = FCI_STROBE;
      end
      FCI_STROBE: begin
        // never both strobes at once
        next_q.pins.out_enable_n = !q.is_read;
        next_q.pins.write_enable_n = q.is_read;
        if (q.tmr != 4'h0) begin
          next_q.tmr = q.tmr - 4'h1;
        end else begin
          next_q.st = FCI_HOLD;
          if (q.is_read) begin
            next_q.rdata = dq_i;
          end
        end
      end
      FCI_HOLD: begin
        // raising write enable is the edge the device latches on
        next_q.pins.out_enable_n = 1'b1;
        next_q.pins.write_enable_n = 1'b1;
        next_q.st = FCI_NEXT;
      end
      FCI_NEXT: begin
        next_q.pins.chip_select_n = 1'b1;
        next_q.pins.dq_oe_n = 1'b1;
        next_q.st = FCI_SETUP;
        unique case (q.op)
          FCI_OP_BUFPROG: begin
            if (q.step == 3'h1 && !q.rdata[XSR_READY_BIT]) begin
              next_q.step = 3'h0; // no buffer free: issue setup again
            end else if (q.step == 3'h3 && q.idx != q.count) begin
              next_q.idx = q.idx + 5'h1;
              next_q.wdata = q.wdata;
            end else if (q.step == 3'h4) begin
              last = 1'b1;
            end else begin
              next_q.step = q.step + 3'h1;
            end
          end
          FCI_OP_ARRAY, FCI_OP_CLEAR, FCI_OP_SUSPEND, FCI_OP_RESUME, FCI_OP_READ: last = 1'b1;
          default: last = q.step == 3'h1;
          endcase
        if (!last) begin
          if (!(q.op == FCI_OP_BUFPROG)) begin
            next_q.step = 3'h1;
          end
        end else begin
          next_q.st = FCI_DONE;
        end
      end
      FCI_DONE: begin
        // flag failure from the status word: bit 5 or bit 4, once ready is set
        next_q.err = q.is_read && q.op == FCI_OP_STATUS && q.rdata[STATUS_READY_BIT] && q.rdata[5:4] != 2'h0;
        next_q.st = FCI_IDLE;
      end
      default: next_q.st = FCI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: FCI_IDLE, pins: '{chip_select_n: 1'b1, out_enable_n: 1'b1, write_enable_n: 1'b1,
             addr: '0, dq_out: '0, dq_oe_n: 1'b1}, addr: '0, wdata: '0, rdata: '0, count: '0,
             idx: '0, step: '0, op: FCI_OP_NONE, is_read: 1'b0, buf_wait: 1'b0, err: 1'b0,
             ack: 1'b0, tmr: '0, rstn: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  // read mux: rdata low byte only for identifier reads
  always_comb begin
    unique case (wb_adr_i)
      REG_CTRL: wb_dat_o = {23'h0, q.rstn, 4'h0, q.op};
      REG_ADDR: wb_dat_o = {9'h0, q.addr};
      REG_DATA: wb_dat_o = {16'h0, q.op == FCI_OP_ID ? {8'h00, q.rdata[7:0]} : q.rdata};
      REG_STAT: wb_dat_o = {28'h0, busy_indicator_out_i, q.err, q.st == FCI_IDLE, q.rdata[STATUS_READY_BIT]};
      default: wb_dat_o = 32'h0;
    endcase
  end

  assign wb_ack_o = q.ack;
  assign pins_o = q.pins;
  assign reset_powerdown_n_o = q.rstn;

  strobe_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(!pins_o.out_enable_n && !pins_o.write_enable_n)) else $error("both strobes low");
  we_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pins_o.write_enable_n) |-> !pins_o.chip_select_n) else $error("write not closed by we");
  drive_on_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pins_o.write_enable_n |-> !pins_o.dq_oe_n) else $error("write without data drive");
  no_drive_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pins_o.out_enable_n |-> pins_o.dq_oe_n) else $error("drive during read");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  count_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.count <= BUF_COUNT_MAX) else $error("count beyond max");
  sequence strobe_open_s;
    $fell(pins_o.write_enable_n) || $fell(pins_o.out_enable_n);
  endsequence
  strobe_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    strobe_open_s |-> ##[4:6] (pins_o.write_enable_n && pins_o.out_enable_n)) else $error("strobe length");
  idle_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.st == FCI_IDLE && $past(q.st) == FCI_IDLE |-> pins_o.chip_select_n) else $error("selected while idle");
endmodule : fci_host

// file: fci_pkg.sv
//------------------------------------------------------------
// constants and carriers of the flash command controller
//------------------------------------------------------------
package fci_pkg;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BUF_SETUP = 8'hE8;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CONFIG = 8'hB8;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_MASTER = 8'hF1;
  localparam logic [4:0] BUF_COUNT_MAX = 5'h1F;
  localparam int unsigned STATUS_READY_BIT = 7;
  localparam int unsigned XSR_READY_BIT = 7;
  localparam int unsigned ADDR_W = 23;
  // bus timing: the strobe lasts this many clocks plus one; setup and hold take one clock each
  localparam real CLK_PERIOD_NS = 20.0;
  localparam real STROBE_NS = 70.0;
  localparam logic [3:0] STROBE_CYC = 4'(int'((STROBE_NS + CLK_PERIOD_NS - 1.0) / CLK_PERIOD_NS));
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  // operation codes written into the control register
  typedef enum logic [3:0] {
    FCI_OP_NONE, FCI_OP_ARRAY, FCI_OP_READ, FCI_OP_ID, FCI_OP_QUERY, FCI_OP_STATUS,
    FCI_OP_CLEAR, FCI_OP_PROG, FCI_OP_ERASE, FCI_OP_SUSPEND, FCI_OP_RESUME,
    FCI_OP_CONFIG, FCI_OP_LOCK_BLK, FCI_OP_LOCK_MST, FCI_OP_UNLOCK, FCI_OP_BUFPROG
  } fci_op_e;
  typedef enum logic [2:0] {
    FCI_IDLE, FCI_SETUP, FCI_STROBE, FCI_HOLD, FCI_NEXT, FCI_DONE
  } fci_st_e;
  // flash pins driven by the controller
  typedef struct packed {
    logic chip_select_n;
    logic out_enable_n;
    logic write_enable_n;
    logic [ADDR_W-1:0] addr;
    logic [15:0] dq_out;
    logic dq_oe_n;
  } fci_pins_s;
endpackage : fci_pkg

// file: fci_flash_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// behavioural flash device behind the controller pins
// ------------------------------------------------------------
module fci_flash_model #(
  parameter int BUSY_NS = 2000,
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C // arbitrary value
) (
  input wire fci_pkg::fci_pins_s pins_i,
  input wire logic reset_powerdown_n_i,
  input wire logic high_voltage_i,
  input wire logic program_enable_i,
  output logic [15:0] dq_o,
  output logic busy_indicator_out_o
);
  import fci_pkg::*;
  typedef enum logic [1:0] {M_ARRAY, M_ID, M_QUERY, M_STATUS} fci_fm_mode_e;
  typedef enum logic [2:0] {S_NONE, S_PROG, S_ERASE, S_LOCK, S_CONF, S_COUNT, S_DATA, S_CONFIRM} fci_fm_step_e;
  fci_fm_mode_e mode;
  fci_fm_step_e step, s;
  logic [15:0] mem [256];
  logic [15:0] bdat [32];
  logic [7:0] badr [32];
  logic [15:0] lk, rd, fl;
  logic [7:0] sr, cfg;
  logic master, running;
  logic [4:0] cnt, n;
  event go;
  wire logic [7:0] a = pins_i.addr[7:0];
  wire logic [7:0] d = pins_i.dq_out[7:0]; // upper byte ignored
  wire logic wr_n = pins_i.chip_select_n | pins_i.write_enable_n; // terminating edge
  wire logic lock_ok = program_enable_i && (!master || high_voltage_i);
  function automatic logic ok(input logic [3:0] b);
    return program_enable_i && (!lk[b] || high_voltage_i);
  endfunction : ok
  task automatic run(input logic g);
    if (g)
      ->go;
    else
      sr[4] = 1'b1;
  endtask : run
  // erased array, no locks, idle sequencer
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    lk = '0;
    master = 1'b0;
    running = 1'b0;
  end
  // command decoder; a step other than idle leaves the part in status mode
  always @(posedge wr_n or negedge reset_powerdown_n_i) begin
    if (!reset_powerdown_n_i) begin
      mode = M_ARRAY;
      step = S_NONE;
      sr = 8'h80;
    end else begin
      s = step;
      step = S_NONE;
      if (s != S_NONE) mode = M_STATUS;
      case (s)
        S_NONE: case (d)
          CMD_READ_ARRAY: mode = M_ARRAY;
          CMD_READ_ID: mode = M_ID;
          CMD_QUERY: mode = M_QUERY;
          CMD_READ_STATUS: mode = M_STATUS;
          CMD_CLEAR_STATUS: sr[5:3] = 3'h0;
          CMD_BUF_SETUP: step = S_COUNT;
          CMD_PROG_SETUP, CMD_PROG_ALT: step = S_PROG;
          CMD_ERASE_SETUP: step = S_ERASE;
          CMD_CONFIG: step = S_CONF;
          CMD_LOCK_SETUP: step = S_LOCK;
          CMD_SUSPEND: sr[6] = running;
          CMD_CONFIRM: sr[6] = 1'b0;
          default: ;
        endcase
        S_PROG: begin
          if (ok(a[7:4])) mem[a] = pins_i.dq_out;
          run(ok(a[7:4]));
        end
        S_ERASE: begin
          if (d == CMD_CONFIRM && ok(a[7:4])) for (int i = 0; i < 16; i++) mem[{a[7:4], 4'(i)}] = 16'hFFFF;
          run(d == CMD_CONFIRM && ok(a[7:4]));
        end
        S_LOCK: begin
          if (d == CMD_LOCK_BLOCK && lock_ok) lk[a[7:4]] = 1'b1;
          if (d == CMD_LOCK_MASTER && program_enable_i && high_voltage_i) master = 1'b1;
          if (d == CMD_CONFIRM && lock_ok) lk = '0;
          run(program_enable_i);
        end
        S_CONF: cfg = d;
        S_COUNT: begin
          cnt = d[4:0];
          n = 5'h00;
          step = S_DATA;
        end
        S_DATA: begin
          badr[n] = a;
          bdat[n] = pins_i.dq_out;
          step = (n == cnt) ? S_CONFIRM : S_DATA;
          n = n + 5'h01;
        end
        default: begin
          if (d == CMD_CONFIRM && ok(a[7:4])) for (int i = 0; i <= cnt; i++) mem[badr[i]] = bdat[i];
          run(d == CMD_CONFIRM && ok(a[7:4])); // other commands abort
        end
      endcase
    end
  end
  // sequencer run time
  always @(go) begin
    running = 1'b1;
    #(BUSY_NS);
    running = 1'b0;
  end
  // read mux; undriven lines show the inverse so a stale value cannot pass
  always @* begin
    fl = 16'h0000;
    case (mode)
      M_ARRAY: rd = mem[a];
      M_ID: rd = {8'h00, a[2:1] == 2'h0 ? MFR_CODE : a[2:1] == 2'h1 ? DEV_CODE : {7'h00, a[1] ? master : lk[a[7:4]]}};
      M_QUERY: rd = {8'h00, a == 8'h10 ? 8'h51 : a == 8'h11 ? 8'h52 : a == 8'h12 ? 8'h59 : 8'h00};
      default: begin
        rd = {8'h00, !running, sr[6:0]};
        fl = running ? 16'hFF7F : 16'h0000;
      end
    endcase
    if (step == S_COUNT) rd = 16'h0080; // buffer always free
    dq_o = (!pins_i.chip_select_n && !pins_i.out_enable_n && reset_powerdown_n_i) ? rd ^ fl : ~rd;
  end
  assign busy_indicator_out_o = !(running && !sr[6]) || !reset_powerdown_n_i;
endmodule : fci_flash_model

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import fci_pkg::*;
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DEV = 8'h3C; // arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic hv = 1'b0;
  logic pe = 1'b1;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, busy, rstn;
  logic [15:0] dq;
  fci_pins_s pins;
  int fail_count = 0;
  int num_checks = 0;
  int cnts [2] = '{1, 31};
  always #10 clk_i = ~clk_i;
  fci_host i_fci_host (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .pins_o(pins), .dq_i(dq), .busy_indicator_out_i(busy), .reset_powerdown_n_o(rstn));
  fci_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_fci_flash_model (.pins_i(pins), .reset_powerdown_n_i(rstn),
    .high_voltage_i(hv), .program_enable_i(pe), .dq_o(dq), .busy_indicator_out_o(busy));
  // one classic wishbone cycle, entered just after a rising edge
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) fail_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // start an operation and poll until idle, optionally until the busy pin is released too
  task automatic op(input fci_op_e o, input logic [22:0] a, input logic [15:0] d, input logic [4:0] n, input logic hold);
    int k;
    wb(REG_ADDR, 1'b1, {9'h000, a});
    wb(REG_DATA, 1'b1, {16'h0000, d});
    wb(REG_CTRL, 1'b1, {11'h000, n, 7'h00, 1'b1, 4'h0, o});
    k = 0;
    do begin
      wb(REG_STAT, 1'b0, 32'h0);
      k++;
    end while ((q[1] !== 1'b1 || (hold && q[3] !== 1'b1)) && k < 300);
    if (k >= 300) fail_count++;
  endtask : op
  task automatic rd(input logic [22:0] a);
    op(FCI_OP_READ, a, 16'h0000, 5'h00, 1'b1);
    wb(REG_DATA, 1'b0, 32'h0);
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    chk("pins in reset", 16'h001E, {11'h000, pins.chip_select_n, pins.out_enable_n, pins.write_enable_n, pins.dq_oe_n, rstn});
    rst_i <= 1'b0;
    wb(REG_STAT, 1'b0, 32'h0);
    chk("idle", 16'h0002, q[15:0] & 16'h0002);
    op(FCI_OP_NONE, 23'h0, 16'h0, 5'h0, 1'b1);
    rd(23'h05);
    chk("array after reset", 16'hFFFF, q[15:0]);
    op(FCI_OP_STATUS, 23'h0, 16'h0, 5'h0, 1'b1);
    rd(23'h33);
    chk("status after reset", 16'h0080, q[15:0]);
    op(FCI_OP_PROG, 23'h12, 16'hA55A, 5'h0, 1'b0);
    chk("busy pin", 16'h0000, {15'h0, q[3]});
    rd(23'h12);
    chk("ready bit while busy", 16'h0000, {15'h0, q[7]});
    op(FCI_OP_ARRAY, 23'h0, 16'h0, 5'h0, 1'b1);
    rd(23'h12);
    chk("programmed word", 16'hA55A, q[15:0]);
    op(FCI_OP_ID, 23'h0, 16'h0, 5'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(23'(i));
      chk("identifier", {8'h00, i < 2 ? MFR : DEV}, q[15:0]);
    end
    op(FCI_OP_QUERY, 23'h0, 16'h0, 5'h0, 1'b1);
    rd(23'h10);
    chk("query", 16'h0051, q[15:0]);
    foreach (cnts[j]) begin
      op(FCI_OP_BUFPROG, 23'h20 + 23'(64 * j), 16'h0BE0 + 16'(j), 5'(cnts[j]), 1'b1);
      op(FCI_OP_ARRAY, 23'h0, 16'h0, 5'h0, 1'b1);
      for (int i = cnts[j]; i < cnts[j] + 2; i++) begin
        rd(23'h20 + 23'(64 * j) + 23'(i));
        chk("buffered word", i <= cnts[j] ? 16'h0BE0 + 16'(j) : 16'hFFFF, q[15:0]);
      end
    end
    op(FCI_OP_LOCK_BLK, 23'h40, 16'h0, 5'h0, 1'b1);
    op(FCI_OP_PROG, 23'h41, 16'h1111, 5'h0, 1'b1);
    hv <= 1'b1;
    op(FCI_OP_PROG, 23'h42, 16'h2222, 5'h0, 1'b1);
    hv <= 1'b0;
    pe <= 1'b0;
    op(FCI_OP_PROG, 23'h50, 16'h3333, 5'h0, 1'b1);
    pe <= 1'b1;
    rd(23'h0);
    chk("failed program flag", 16'h0090, q[15:0]);
    op(FCI_OP_STATUS, 23'h0, 16'h0, 5'h0, 1'b1);
    chk("error flag", 16'h0005, q[15:0] & 16'h0005);
    op(FCI_OP_CLEAR, 23'h0, 16'h0, 5'h0, 1'b1);
    rd(23'h0);
    chk("cleared status", 16'h0080, q[15:0]);
    op(FCI_OP_UNLOCK, 23'h0, 16'h0, 5'h0, 1'b1);
    op(FCI_OP_PROG, 23'h41, 16'h1111, 5'h0, 1'b1);
    op(FCI_OP_ERASE, 23'h12, 16'h0, 5'h0, 1'b0);
    op(FCI_OP_SUSPEND, 23'h0, 16'h0, 5'h0, 1'b0);
    chk("busy after suspend", 16'h0001, {15'h0, q[3]});
    op(FCI_OP_RESUME, 23'h0, 16'h0, 5'h0, 1'b0);
    chk("busy after resume", 16'h0000, {15'h0, q[3]});
    op(FCI_OP_ARRAY, 23'h0, 16'h0, 5'h0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      rd(i == 0 ? 23'h12 : i == 1 ? 23'h20 : i == 2 ? 23'h41 : i == 3 ? 23'h42 : 23'h50);
      chk("array word", i == 0 ? 16'hFFFF : i == 1 ? 16'h0BE0 : i == 2 ? 16'h1111 : i == 3 ? 16'h2222 : 16'hFFFF, q[15:0]);
    end
    // configuration code, then master lock with high voltage; a later block lock without it must not stick
    op(FCI_OP_CONFIG, 23'h0, 16'h0001, 5'h0, 1'b1);
    rd(23'h0);
    chk("status after config", 16'h0080, q[15:0]);
    hv <= 1'b1;
    op(FCI_OP_LOCK_MST, 23'h0, 16'h0, 5'h0, 1'b1);
    hv <= 1'b0;
    op(FCI_OP_LOCK_BLK, 23'h40, 16'h0, 5'h0, 1'b1);
    op(FCI_OP_ID, 23'h0, 16'h0, 5'h0, 1'b1);
    rd(23'h06);
    chk("master lock code", 16'h0001, q[15:0]);
    rd(23'h44);
    chk("block lock code", 16'h0000, q[15:0]);
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    #1000000;
    fail_count++;
    summarize();
  end
endmodule : tb_top
